// File: sfs_consts.svh
// constants for the serial flash status-write and read block
// assumes a 100 MHz system clock and an spi mode 0/3 master on the pins
// Overview of operation
// [R1] status write accepted only when the write enable latch is set
// [R2] master sends opcode then exactly one status data byte
// [R3] status write changes only bits 7, 3 and 2
// [R4] status bits 6, 5, 4 always read zero
// [R5] select rise anywhere but after data bit eight discards the write
// [R6] valid status write starts a timed cycle with busy high until done
// [R7] status reads still served while the timed cycle runs
// [R8] write enable latch cleared during the timed cycle
// [R9] status write updates both block protect bits and the lock bit
// [R10] hardware protected mode refuses every status write
// [R11] lock bit zero after delivery; writes then ignore the protect pin
// [R12] lock bit set and protect pin high: write allowed with latch set
// [R13] lock bit set and protect pin low: every status write rejected
// [R14] hardware protection entered whichever of pin and bit comes last
// [R15] only the protect pin going high leaves hardware protection
// [R16] protected area refuses program and erase; unprotected area accepts
// [R17] read: opcode then three address bytes, bits taken on sclk rise
// [R18] read data leaves on falling sclk edges after the address
// [R19] read address increments per byte and wraps to zero
// [R20] select rise ends the read and releases the data pin
// [R21] read refused while a timed cycle runs; cycle continues
// [R22] address bits 23 to 18 ignored, lower 18 decoded
// [R23] all codes, addresses and data move msb first
// [R24] completed write unlock instruction sets the write enable latch
// [R25] status byte: busy b0, latch b1, protect b2/b3, lock b7
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_CLK_PERIOD_NS 10
`define SFS_STATUS_CYCLE_NS 15000000
`define SFS_OP_WRITE_UNLOCK 8'h06
`define SFS_OP_WRITE_LOCK 8'h04
`define SFS_OP_STATUS_READ 8'h05
`define SFS_OP_STATUS_WRITE 8'h01
`define SFS_OP_PLAIN_READ 8'h03
`define SFS_ST_BUSY 0
`define SFS_ST_WEL 1
`define SFS_ST_BP_LO 2
`define SFS_ST_BP_HI 3
`define SFS_ST_LOCK 7
`define SFS_ADDR_W 18
`define SFS_ADDR_BYTES 2'h2
`define SFS_PIN_RST 4'h2
`define SFS_BP_RST 2'h0
`define SFS_LOCK_RST 1'h0
`endif

// File: sfs_pkg.sv
// types shared by the serial flash status-write and read block
// assumes the constants header is compiled alongside
package sfs_pkg;
	// instruction phase while the chip is selected
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_OPC,
		PH_ADDR,
		PH_STATUS_WRITE_INSTR_DATA,
		PH_CMD_END,
		PH_STATUS_WRITE_INSTR_END,
		PH_READ_OUT,
		PH_STAT_OUT
	} sfs_phase_t;
	typedef logic [7:0] sfs_byte_t;
endpackage

// File: sfs_sync.sv
// two-flop synchroniser for the spi pins
// assumes pins are asynchronous to clk_sys
`timescale 1ns/1ns
`include "sfs_consts.svh"
module sfs_sync (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic [3:0] pinIn,
	output logic [3:0] pinSync
);
	localparam logic [3:0] PIN_RST = `SFS_PIN_RST;
	logic [3:0] meta_q;
	genvar i;
	// one pair of flops per pin, first stage feeds second only
	generate
		for (i = 0; i < 4; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					meta_q[i] <= PIN_RST[i];
					pinSync[i] <= PIN_RST[i];
				end else if (clkEn) begin
					meta_q[i] <= pinIn[i];
					pinSync[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule

// File: sfs_array.sv
// byte array behind the plain read path
// assumes the preload port is driven from clk_sys logic
`timescale 1ns/1ns
`include "sfs_consts.svh"
module sfs_array (
	input wire logic clk_sys,
	input wire logic clkEn,
	input wire logic loadEn,
	input wire logic [17:0] loadAddr,
	input wire logic [7:0] loadData,
	input wire logic [17:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [0:(1<<`SFS_ADDR_W)-1];
	// preload write, no reset on the array
	always_ff @(posedge clk_sys) begin
		if (clkEn && loadEn) begin
			mem[loadAddr] <= loadData;
		end
	end
	// read is combinational so the byte is ready at the first falling edge
	assign rdData = mem[rdAddr];
endmodule

// File: sfs_core.sv
// serial flash command handling: status write, protection modes, plain read
// assumes sclk at most clk_sys/8; pins are oversampled through synchronisers
`timescale 1ns/1ns
`include "sfs_consts.svh"
module sfs_core #(
	parameter int unsigned STATUS_CYCLE_NS = `SFS_STATUS_CYCLE_NS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic sclkPin,
	input wire logic csPin_n,
	input wire logic mosiPin,
	input wire logic wpPin_n,
	output logic misoQ,
	output logic misoOe_n,
	output logic [7:0] statusQ,
	output logic busyQ,
	output logic welQ,
	output logic hwProtQ,
	output logic swProtQ,
	input wire logic [17:0] chkAddr,
	output logic chkProtQ,
	output logic bulkOkQ,
	input wire logic loadEn,
	input wire logic [17:0] loadAddr,
	input wire logic [7:0] loadData
);
	// cycles of the timed status write, rounded up
	localparam logic [31:0] STATUS_CYCLES =
		32'((STATUS_CYCLE_NS + `SFS_CLK_PERIOD_NS - 1) / `SFS_CLK_PERIOD_NS);

	// synchronised pin views and edge history
	logic [3:0] pinSync;
	logic sclkS;
	logic csS_n;
	logic mosiS;
	logic wpS_n;
	logic sclkPrev_q;
	logic csPrev_q;
	// instruction phase, shifters and counters
	sfs_pkg::sfs_phase_t phase_q;
	sfs_pkg::sfs_phase_t phase_d;
	logic [2:0] bitCnt_q;
	logic [1:0] byteCnt_q;
	logic [7:0] shIn_q;
	logic [7:0] opc_q;
	logic [7:0] wrData_q;
	logic [17:0] addr_q;
	logic [17:0] rdAddr_q;
	logic [7:0] outSh_q;
	logic [2:0] outCnt_q;
	// status register state and timed cycle counter
	logic wel_q;
	logic busy_q;
	logic [31:0] cycCnt_q;
	logic [1:0] bp_q;
	logic lock_q;
	// array byte at the read pointer
	logic [7:0] rdData;

	// pin synchronisers, then named views of each pin
	sfs_sync u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.pinIn({wpPin_n, mosiPin, csPin_n, sclkPin}),
		.pinSync(pinSync)
	);
	assign sclkS = pinSync[0];
	assign csS_n = pinSync[1];
	assign mosiS = pinSync[2];
	assign wpS_n = pinSync[3];

	// memory array for the plain read
	sfs_array u_array (
		.clk_sys(clk_sys),
		.clkEn(clkEn),
		.loadEn(loadEn),
		.loadAddr(loadAddr),
		.loadData(loadData),
		.rdAddr(rdAddr_q),
		.rdData(rdData)
	);

	// edge detection on the synchronised pins
	wire sclkRise = sclkS & ~sclkPrev_q;
	wire sclkFall = ~sclkS & sclkPrev_q;
	wire csFall = ~csS_n & csPrev_q;
	wire csRise = csS_n & ~csPrev_q;
	wire selRise = sclkRise & ~csS_n;
	wire byteEnd = selRise & (bitCnt_q == 3'h7);
	wire [7:0] inByte = {shIn_q[6:0], mosiS};

	// hardware protection follows pin and lock bit in either order
	wire hwProt = lock_q & ~wpS_n; // [R13] [R14] [R15]

	// status byte as read, bits 6..4 forced to zero
	wire [7:0] statusByte = {lock_q, 3'h0, bp_q, wel_q, busy_q}; // [R4] [R25]

	// commit conditions at the select rise
	wire atWrsrEnd = (phase_q == sfs_pkg::PH_STATUS_WRITE_INSTR_END);
	wire atCmdEnd = (phase_q == sfs_pkg::PH_CMD_END);
	wire wrenGo = csRise & atCmdEnd & (opc_q == `SFS_OP_WRITE_UNLOCK); // [R24]
	wire wrdiGo = csRise & atCmdEnd & (opc_q == `SFS_OP_WRITE_LOCK);
	// a status write needs the latch, and no hardware protection
	wire wrsrGo = csRise & atWrsrEnd & wel_q & ~hwProt; // [R1] [R5] [R10] [R11] [R12]
	wire cycDone = busy_q & (cycCnt_q == STATUS_CYCLES - 32'h1);
	wire cycFirst = busy_q & (cycCnt_q == 32'h0);

	// output side of the read and status sequences
	wire outPhase = (phase_q == sfs_pkg::PH_READ_OUT) |
		(phase_q == sfs_pkg::PH_STAT_OUT);
	wire outEdge = sclkFall & outPhase & ~csS_n;
	wire [7:0] freshByte = (phase_q == sfs_pkg::PH_READ_OUT) ? rdData : statusByte;
	wire addrDone = byteEnd & (phase_q == sfs_pkg::PH_ADDR) &
		(byteCnt_q == `SFS_ADDR_BYTES);

	// protected area check: sector from the top two address bits
	wire [1:0] chkSector = chkAddr[17:16];
	wire chkHit = (bp_q == 2'h3) |
		((bp_q == 2'h2) & chkSector[1]) |
		((bp_q == 2'h1) & (chkSector == 2'h3));

	// phase sequencing of one instruction
	always_comb begin
		phase_d = phase_q;
		if (csFall) begin
			phase_d = sfs_pkg::PH_OPC;
		end else if (csS_n) begin
			phase_d = sfs_pkg::PH_IDLE; // [R20]
		end else if (selRise) begin
			case (phase_q)
				sfs_pkg::PH_OPC: begin
					if (bitCnt_q == 3'h7) begin
						case (inByte)
							`SFS_OP_WRITE_UNLOCK: phase_d = sfs_pkg::PH_CMD_END;
							`SFS_OP_WRITE_LOCK: phase_d = sfs_pkg::PH_CMD_END;
							`SFS_OP_STATUS_WRITE: phase_d = sfs_pkg::PH_STATUS_WRITE_INSTR_DATA; // [R2]
							`SFS_OP_STATUS_READ: phase_d = sfs_pkg::PH_STAT_OUT; // [R7]
							// read refused while a timed cycle runs
							`SFS_OP_PLAIN_READ: phase_d = busy_q ?
								sfs_pkg::PH_IDLE : sfs_pkg::PH_ADDR; // [R21]
							default: phase_d = sfs_pkg::PH_IDLE;
						endcase
					end
				end
				sfs_pkg::PH_ADDR: begin
					if (addrDone) begin
						phase_d = sfs_pkg::PH_READ_OUT; // [R17]
					end
				end
				sfs_pkg::PH_STATUS_WRITE_INSTR_DATA: begin
					if (bitCnt_q == 3'h7) begin
						phase_d = sfs_pkg::PH_STATUS_WRITE_INSTR_END;
					end
				end
				// any clock past the last byte spoils the instruction
				sfs_pkg::PH_CMD_END: phase_d = sfs_pkg::PH_IDLE; // [R5]
				sfs_pkg::PH_STATUS_WRITE_INSTR_END: phase_d = sfs_pkg::PH_IDLE; // [R5]
				default: phase_d = phase_q;
			endcase
		end
	end

	// edge history and phase register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sclkPrev_q <= 1'h0;
			csPrev_q <= 1'h1;
			phase_q <= sfs_pkg::PH_IDLE;
		end else if (clkEn) begin
			sclkPrev_q <= sclkS;
			csPrev_q <= csS_n;
			phase_q <= phase_d;
		end
	end

	// input shifter and bit counter, msb first on rising sclk
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shIn_q <= 8'h00;
			bitCnt_q <= 3'h0;
		end else if (clkEn) begin
			if (csFall) begin
				bitCnt_q <= 3'h0;
			end else if (selRise) begin
				shIn_q <= inByte; // [R23]
				bitCnt_q <= bitCnt_q + 3'h1;
			end
		end
	end

	// opcode and status data capture
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			opc_q <= 8'h00;
			wrData_q <= 8'h00;
		end else if (clkEn) begin
			if (byteEnd && phase_q == sfs_pkg::PH_OPC) begin
				opc_q <= inByte;
			end
			if (byteEnd && phase_q == sfs_pkg::PH_STATUS_WRITE_INSTR_DATA) begin
				wrData_q <= inByte;
			end
		end
	end

	// address shifter keeps only the low 18 bits
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= 18'h00000;
			byteCnt_q <= 2'h0;
		end else if (clkEn) begin
			if (byteEnd && phase_q == sfs_pkg::PH_OPC) begin
				byteCnt_q <= 2'h0;
			end else if (selRise && phase_q == sfs_pkg::PH_ADDR) begin
				addr_q <= {addr_q[16:0], mosiS}; // [R22]
				if (bitCnt_q == 3'h7) begin
					byteCnt_q <= byteCnt_q + 2'h1;
				end
			end
		end
	end

	// read pointer: loaded after the address, stepped per byte sent
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdAddr_q <= 18'h00000;
		end else if (clkEn) begin
			// upper address bits have already left the 18-bit shifter
			if (addrDone) begin
				rdAddr_q <= {addr_q[16:0], mosiS}; // [R22]
			end else if (outEdge && outCnt_q == 3'h7 &&
				phase_q == sfs_pkg::PH_READ_OUT) begin
				rdAddr_q <= rdAddr_q + 18'h1; // [R19]
			end
		end
	end

	// output shifter, one bit per falling sclk
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			outSh_q <= 8'h00;
			outCnt_q <= 3'h0;
			misoQ <= 1'h0;
		end else if (clkEn) begin
			if (csFall) begin
				outCnt_q <= 3'h0;
			end else if (outEdge) begin
				outCnt_q <= outCnt_q + 3'h1;
				// first fall of a byte loads a fresh one
				if (outCnt_q == 3'h0) begin
					misoQ <= freshByte[7]; // [R18]
					outSh_q <= {freshByte[6:0], 1'h0};
				end else begin
					misoQ <= outSh_q[7]; // [R18] [R23]
					outSh_q <= {outSh_q[6:0], 1'h0};
				end
			end
		end
	end

	// data pin enable, low while driving
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			misoOe_n <= 1'h1;
		end else if (clkEn) begin
			if (csS_n) begin
				misoOe_n <= 1'h1; // [R20]
			end else if (outEdge) begin
				misoOe_n <= 1'h0;
			end
		end
	end

	// write enable latch: set by unlock, cleared by lock or timed cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wel_q <= 1'h0;
		end else if (clkEn) begin
			// unlock has priority over both clears
			if (wrenGo) begin
				wel_q <= 1'h1; // [R24]
			end else if (wrdiGo || cycFirst) begin
				wel_q <= 1'h0; // [R8]
			end
		end
	end

	// timed status write cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'h0;
			cycCnt_q <= 32'h0;
		end else if (clkEn) begin
			// a status write arriving while busy is dropped
			if (wrsrGo && !busy_q) begin
				busy_q <= 1'h1; // [R6]
				cycCnt_q <= 32'h0;
			end else if (cycDone) begin
				busy_q <= 1'h0; // [R6]
			end else if (busy_q) begin
				cycCnt_q <= cycCnt_q + 32'h1;
			end
		end
	end

	// non-volatile bits: only protect and lock take new data
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bp_q <= `SFS_BP_RST;
			lock_q <= `SFS_LOCK_RST; // [R11]
		end else if (clkEn) begin
			if (wrsrGo && !busy_q) begin
				bp_q <= {wrData_q[`SFS_ST_BP_HI], wrData_q[`SFS_ST_BP_LO]}; // [R3] [R9]
				lock_q <= wrData_q[`SFS_ST_LOCK]; // [R3] [R9]
			end
		end
	end

	// registered status and protection outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			statusQ <= 8'h00;
			busyQ <= 1'h0;
			welQ <= 1'h0;
			hwProtQ <= 1'h0;
			swProtQ <= 1'h1;
			chkProtQ <= 1'h0;
			bulkOkQ <= 1'h1;
		end else if (clkEn) begin
			statusQ <= statusByte;
			busyQ <= busy_q;
			welQ <= wel_q;
			hwProtQ <= hwProt; // [R15]
			swProtQ <= ~hwProt;
			chkProtQ <= chkHit; // [R16]
			bulkOkQ <= (bp_q == 2'h0); // [R16]
		end
	end
endmodule

// File: sfs_sva.sv
// port assertions for the status-write and read block
// assumes it is bound into sfs_core; checks pause while clkEn is low
`timescale 1ns/1ns
`include "sfs_consts.svh"
module sfs_sva #(
	parameter int unsigned STATUS_CYCLE_NS = 200
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic csPin_n,
	input wire logic wpPin_n,
	input wire logic misoOe_n,
	input wire logic [7:0] statusQ,
	input wire logic busyQ,
	input wire logic welQ,
	input wire logic hwProtQ,
	input wire logic bulkOkQ
);
	localparam int CYC = STATUS_CYCLE_NS / `SFS_CLK_PERIOD_NS;
	logic [31:0] busyCnt_q;
	// length of the running busy stretch
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busyCnt_q <= 32'h0;
		end else if (clkEn) begin
			busyCnt_q <= busyQ ? busyCnt_q + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n || !clkEn);
	// multi-step conditions
	sequence s_lockLow;
		(statusQ[7] && !wpPin_n) [*5];
	endsequence
	sequence s_csIdle;
		csPin_n [*6];
	endsequence
	sequence s_busyGo;
		$rose(busyQ) && csPin_n;
	endsequence
	property p_zero;
		statusQ[6:4] == 3'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("upper status bits set");
	property p_bulk;
		bulkOkQ == (statusQ[3:2] == 2'h0);
	endproperty
	a_bulk: assert property (p_bulk) else $error("bulk flag wrong");
	property p_hwIn;
		s_lockLow |-> hwProtQ;
	endproperty
	a_hwIn: assert property (p_hwIn) else $error("protect mode not entered");
	property p_hwOut;
		$rose(wpPin_n) |-> ##[1:4] !hwProtQ;
	endproperty
	a_hwOut: assert property (p_hwOut) else $error("protect mode not left");
	property p_ro;
		hwProtQ && $past(hwProtQ) |-> $stable(statusQ[7:2]);
	endproperty
	a_ro: assert property (p_ro) else $error("locked bits changed");
	property p_busyGo;
		s_busyGo |-> ##[0:2] !welQ;
	endproperty
	a_busyGo: assert property (p_busyGo) else $error("busy start wrong");
	property p_busyLen;
		$fell(busyQ) |-> busyCnt_q >= CYC - 1 && busyCnt_q <= CYC + 1;
	endproperty
	a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
	property p_misoOff;
		s_csIdle |-> misoOe_n;
	endproperty
	a_misoOff: assert property (p_misoOff) else $error("data pin driven");
	property p_welRise;
		$rose(welQ) |-> csPin_n;
	endproperty
	a_welRise: assert property (p_welRise) else $error("latch set mid frame");
endmodule
bind sfs_core sfs_sva #(.STATUS_CYCLE_NS(STATUS_CYCLE_NS)) u_sfs_sva (
	.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .csPin_n(csPin_n), .wpPin_n(wpPin_n),
	.misoOe_n(misoOe_n), .statusQ(statusQ), .busyQ(busyQ), .welQ(welQ),
	.hwProtQ(hwProtQ), .bulkOkQ(bulkOkQ)
);

// File: sfs_host_model.sv
// spi master model framing instructions for the flash block
// assumes mode 0 timing, five system clocks per sclk phase
`timescale 1ns/1ns
module sfs_host_model (
	input wire logic clk_sys,
	input wire logic misoQ,
	input wire logic misoOe_n,
	output logic sclkPin,
	output logic csPin_n,
	output logic mosiPin
);
	logic [7:0] rx;
	// idle bus: deselected, clock low
	initial begin
		sclkPin = 1'b0;
		csPin_n = 1'b1;
		mosiPin = 1'b0;
		rx = 8'h00;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// select with setup ahead of the first rise
	task automatic sel();
		wt(1);
		csPin_n = 1'b0;
		wt(5);
	endtask
	// n bits msb first; reply sampled at each rise
	task automatic xfer(input logic [7:0] d, input int n);
		for (int k = 0; k < n; k++) begin
			mosiPin = d[7 - (k % 8)];
			wt(5);
			sclkPin = 1'b1;
			// a released data line reads as the inverse of its last level
			rx = {rx[6:0], misoOe_n ? ~misoQ : misoQ};
			wt(5);
			sclkPin = 1'b0;
		end
	endtask
	// deselect after the last fall; the mosi line toggles
	task automatic desel();
		wt(5);
		csPin_n = 1'b1;
		mosiPin = ~mosiPin;
		wt(10);
	endtask
	task automatic cmd(input logic [7:0] op);
		sel();
		xfer(op, 8);
		desel();
	endtask
	// status write carrying n data bits
	task automatic wsr(input logic [7:0] d, input int n);
		sel();
		xfer(8'h01, 8);
		xfer(d, n);
		desel();
	endtask
endmodule

// File: tb.sv
// self-checking bench for the status-write and read block
// assumes the host model frames every instruction on the pins
`timescale 1ns/1ns
`define HOST u_sfs_host_model
`define SFS_CHK(g, e) begin \
	totalChecks++; \
	if ((g) !== (e)) begin \
		failCount++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb;
	logic clk_sys, reset_n, wpPin_n, loadEn, sclkPin, csPin_n, mosiPin, misoQ, misoOe_n;
	logic busyQ, welQ, hwProtQ, swProtQ, chkProtQ, bulkOkQ, clkEn;
	logic [7:0] statusQ, loadData;
	logic [17:0] chkAddr, loadAddr;
	int failCount, totalChecks;
	sfs_core #(.STATUS_CYCLE_NS(20000)) u_sfs_core (
		.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .sclkPin(sclkPin),
		.csPin_n(csPin_n), .mosiPin(mosiPin), .wpPin_n(wpPin_n), .misoQ(misoQ),
		.misoOe_n(misoOe_n), .statusQ(statusQ), .busyQ(busyQ), .welQ(welQ),
		.hwProtQ(hwProtQ), .swProtQ(swProtQ), .chkAddr(chkAddr), .chkProtQ(chkProtQ),
		.bulkOkQ(bulkOkQ), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData)
	);
	sfs_host_model u_sfs_host_model (
		.clk_sys(clk_sys), .misoQ(misoQ), .misoOe_n(misoOe_n), .sclkPin(sclkPin),
		.csPin_n(csPin_n), .mosiPin(mosiPin)
	);
	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		if (failCount == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// bounded wait for the timed cycle to end
	task automatic idle();
		for (int n = 0; n < 3000 && busyQ !== 1'b0; n++)
			wt(1);
		`SFS_CHK(busyQ, 1'b0)
		if (busyQ !== 1'b0)
			final_report();
	endtask
	task automatic ld(input logic [17:0] a, input logic [7:0] d);
		loadAddr = a;
		loadData = d;
		loadEn = 1'b1;
		wt(1);
		loadEn = 1'b0;
		wt(1);
	endtask
	task automatic t_reset();
		`SFS_CHK({statusQ, busyQ, welQ, hwProtQ, swProtQ, bulkOkQ, misoOe_n}, 14'h7)
	endtask
	task automatic t_refuse();
		`HOST.wsr(8'h8c, 8);
		`HOST.cmd(8'h06);
		`SFS_CHK(welQ, 1'b1)
		`HOST.wsr(8'h8c, 7);
		`HOST.wsr(8'h8c, 9);
		wt(20);
		`SFS_CHK({busyQ, statusQ[7:2]}, 7'h00)
		`HOST.cmd(8'h04);
		`SFS_CHK(welQ, 1'b0)
		`HOST.wsr(8'h8c, 8);
		wt(20);
		`SFS_CHK({busyQ, statusQ[7:2]}, 7'h00)
	endtask
	// frozen clock enable holds the pin view and protection outputs
	task automatic t_freeze();
		clkEn = 1'b0;
		wpPin_n = 1'b0;
		wt(6);
		`SFS_CHK({hwProtQ, swProtQ}, 2'b01)
		clkEn = 1'b1;
		wt(6);
		`SFS_CHK({hwProtQ, swProtQ}, 2'b10)
		wpPin_n = 1'b1;
		wt(6);
		`SFS_CHK({hwProtQ, swProtQ}, 2'b01)
	endtask
	task automatic t_write();
		`HOST.cmd(8'h06);
		`HOST.wsr(8'hff, 8);
		`SFS_CHK(busyQ, 1'b1)
		`HOST.sel();
		`HOST.xfer(8'h05, 8);
		`HOST.xfer(8'h00, 8);
		`SFS_CHK(`HOST.rx, 8'h8d)
		`HOST.desel();
		`HOST.sel();
		`HOST.xfer(8'h03, 8);
		`HOST.xfer(8'h00, 32);
		`SFS_CHK(misoOe_n, 1'b1)
		`HOST.desel();
		idle();
		`SFS_CHK({bulkOkQ, statusQ}, 9'h08c)
	endtask
	task automatic t_protect();
		wpPin_n = 1'b0;
		wt(6);
		`SFS_CHK(hwProtQ, 1'b1)
		`HOST.cmd(8'h06);
		`HOST.wsr(8'h00, 8);
		wt(20);
		`SFS_CHK({busyQ, statusQ[7:2]}, 7'h23)
		wpPin_n = 1'b1;
		wt(6);
		`SFS_CHK(hwProtQ, 1'b0)
		`HOST.cmd(8'h06);
		`HOST.wsr(8'h04, 8);
		idle();
		`SFS_CHK(statusQ, 8'h04)
		chkAddr = 18'h30000;
		wt(2);
		`SFS_CHK(chkProtQ, 1'b1)
		chkAddr = 18'h2ffff;
		wt(2);
		`SFS_CHK({chkProtQ, bulkOkQ}, 2'b00)
		wpPin_n = 1'b0;
		`HOST.cmd(8'h06);
		`HOST.wsr(8'h80, 8);
		idle();
		wt(6);
		`SFS_CHK({hwProtQ, statusQ}, 9'h180)
		wpPin_n = 1'b1;
		wt(6);
	endtask
	task automatic t_read();
		ld(18'h3fffe, 8'ha5);
		ld(18'h3ffff, 8'h3c);
		ld(18'h00000, 8'h81);
		`HOST.sel();
		`HOST.xfer(8'h03, 8);
		`HOST.xfer(8'hff, 16);
		`HOST.xfer(8'hfe, 8);
		`HOST.xfer(8'h00, 8);
		`SFS_CHK(`HOST.rx, 8'ha5)
		`HOST.xfer(8'h00, 8);
		`SFS_CHK(`HOST.rx, 8'h3c)
		`HOST.xfer(8'h00, 8);
		`SFS_CHK(`HOST.rx, 8'h81)
		`HOST.xfer(8'h00, 3);
		`HOST.desel();
		`SFS_CHK(misoOe_n, 1'b1)
	endtask
	// reset, then every scenario in turn
	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		wpPin_n = 1'b1;
		loadEn = 1'b0;
		loadAddr = 18'h0;
		loadData = 8'h00;
		chkAddr = 18'h0;
		failCount = 0;
		totalChecks = 0;
		wt(5);
		reset_n = 1'b1;
		wt(6);
		t_reset();
		t_refuse();
		t_write();
		t_protect();
		t_freeze();
		t_read();
		final_report();
	end
endmodule
